// ==== rtl/smac_top.sv ====
// Control side of the serial adapter: idle sleep, paced refresh, wipe command and value store.
`timescale 1ns/1ps
// How it works
// - Sleep after sixty seconds without any query or issued fetch.
// - Register 1 interval paces instrument reading fetches.
// - Each refresh overwrites the float value registers.
// - Any write to register 3 starts wipe.
// - Intervals above two minutes wipe before reading.
// - Each parameter code has fixed scaled range, except codes 51 to 54, which pass through unscaled.
// - Each float value is a register pair per slot; the scaled value is one register per slot.
module smac_top #(
	parameter int TICKS_PER_SEC = smac_pkg::TICKS_PER_SEC
) (
	input  wire logic        ref_clk_i,
	input  wire logic        reset_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	input  wire logic [15:0] reg_addr_i,
	input  wire logic [15:0] reg_wdata_i,
	output logic      [15:0] reg_rdata_o,
	output logic             reg_ack_o,
	output logic             fetch_req_o,
	input  wire logic        fetch_done_i,
	output logic             wipe_req_o,
	input  wire logic        meas_valid_i,
	input  wire logic [4:0]  meas_slot_i,
	input  wire logic [31:0] meas_float_i,
	input  wire logic [31:0] meas_fixed_i,
	output logic             sleep_o,
	output logic             wipe_busy_o
);
	import smac_pkg::*;

	logic        [31:0] tick_cnt_r;
	logic               sec_tick;
	logic        [15:0] interval_r;
	logic        [15:0] samp_cnt_r;
	logic        [7:0]  idle_cnt_r;
	logic               sleep_r;
	logic        [7:0]  wipe_cnt_r;
	smac_state_e        st_r;
	logic               query;
	logic               start_refresh;
	logic               wipe_cmd;
	logic        [31:0] float_mem [NUM_SLOTS];
	logic        [31:0] fixed_mem [NUM_SLOTS];
	logic        [7:0]  code_mem  [NUM_SLOTS];
	logic        [15:0] float_off;
	logic        [15:0] code_off;
	logic        [15:0] scale_off;
	logic        [4:0]  scale_slot;
	logic        [15:0] scaled;
	logic        [15:0] rdata_nxt;
	logic        [63:0] scale_rng;
	logic               wipe_busy_r;

	assign query         = reg_wr_i | reg_rd_i;
	assign wipe_cmd      = reg_wr_i && (reg_addr_i == REG_WIPE);
	assign start_refresh = (st_r == SMAC_IDLE) && sec_tick && (interval_r != INTERVAL_RST)
	                       && ((samp_cnt_r + 16'h0001) >= interval_r);
	assign float_off     = reg_addr_i - REG_FLOAT_BASE;
	assign code_off      = reg_addr_i - REG_CODE_BASE;
	assign scale_off     = reg_addr_i - REG_SCALE_BASE;
	assign scale_slot    = scale_off[4:0];
	assign sec_tick      = (tick_cnt_r == 32'(TICKS_PER_SEC - 1));
	assign sleep_o       = sleep_r;
	assign wipe_busy_o   = wipe_busy_r;
	assign scale_rng     = smac_range(code_mem[scale_slot]);

	// One-second enable pulse from the reference clock.
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			tick_cnt_r <= 32'h0;
		end else if (sec_tick) begin
			tick_cnt_r <= 32'h0;
		end else begin
			tick_cnt_r <= tick_cnt_r + 32'h1;
		end
	end

	// Idle timer: any query or issued fetch restarts it; at sixty seconds the adapter sleeps.
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			idle_cnt_r <= 8'h0;
			sleep_r    <= 1'b0;
		end else if (query || fetch_req_o) begin
			idle_cnt_r <= 8'h0;
			sleep_r    <= 1'b0;
		end else if (sec_tick && !sleep_r) begin
			if (idle_cnt_r == 8'(IDLE_SLEEP_S - 1)) begin
				sleep_r <= 1'b1;
			end else begin
				idle_cnt_r <= idle_cnt_r + 8'h1;
			end
		end
	end

	// Sample interval register; a value of zero disables paced refresh.
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			interval_r <= INTERVAL_RST;
		end else if (reg_wr_i && (reg_addr_i == REG_INTERVAL)) begin
			interval_r <= reg_wdata_i;
		end
	end

	// Seconds elapsed in the current sample interval.
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			samp_cnt_r <= 16'h0;
		end else if (start_refresh || (interval_r == INTERVAL_RST)) begin
			samp_cnt_r <= 16'h0;
		end else if (sec_tick && (st_r == SMAC_IDLE)) begin
			samp_cnt_r <= samp_cnt_r + 16'h1;
		end
	end

	// Refresh sequencer: long intervals wipe first, then a fetch is requested and awaited.
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			st_r        <= SMAC_IDLE;
			fetch_req_o <= 1'b0;
		end else begin
			fetch_req_o <= 1'b0;
			case (st_r)
				SMAC_IDLE: begin
					if (start_refresh && (interval_r > 16'(AUTO_WIPE_S))) begin
						st_r <= SMAC_WIPE;
					end else if (start_refresh) begin
						st_r        <= SMAC_FETCH;
						fetch_req_o <= 1'b1;
					end
				end
				SMAC_WIPE: begin
					if (sec_tick && (wipe_cnt_r == 8'h01)) begin
						st_r        <= SMAC_FETCH;
						fetch_req_o <= 1'b1;
					end
				end
				SMAC_FETCH: begin
					if (fetch_done_i) begin
						st_r <= SMAC_IDLE;
					end
				end
				default: begin
					st_r <= SMAC_IDLE;
				end
			endcase
		end
	end

	// Wipe command pulse and the sixty-second busy window that follows it.
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			wipe_req_o  <= 1'b0;
			wipe_cnt_r  <= 8'h0;
			wipe_busy_r <= 1'b0;
		end else if (wipe_cmd || (start_refresh && (interval_r > 16'(AUTO_WIPE_S)))) begin
			wipe_req_o  <= 1'b1;
			wipe_cnt_r  <= 8'(WIPE_TIME_S);
			wipe_busy_r <= 1'b1;
		end else begin
			wipe_req_o <= 1'b0;
			if (sec_tick && (wipe_cnt_r != 8'h00)) begin
				wipe_cnt_r  <= wipe_cnt_r - 8'h1;
				wipe_busy_r <= (wipe_cnt_r != 8'h01); // Busy drops with the last second of the window.
			end
		end
	end

	// Measurement store: each returned reading overwrites its slot.
	always_ff @(posedge ref_clk_i) begin
		if (meas_valid_i) begin
			float_mem[meas_slot_i] <= meas_float_i;
			fixed_mem[meas_slot_i] <= meas_fixed_i;
		end
	end

	// Parameter code map, written by the host.
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			for (int i = 0; i < NUM_SLOTS; i++) begin
				code_mem[i] <= 8'h00;
			end
		end else if (reg_wr_i && (code_off < 16'(NUM_SLOTS))) begin
			code_mem[code_off[4:0]] <= reg_wdata_i[7:0];
		end
	end

	smac_scaler u_scaler (
		.code_i   (code_mem[scale_slot]),
		.value_i  (fixed_mem[scale_slot]),
		.scaled_o (scaled)
	);

	// Read decode; unmapped and write-only registers read as zero.
	always_comb begin
		rdata_nxt = 16'h0000;
		if (reg_addr_i == REG_INTERVAL) begin
			rdata_nxt = interval_r;
		end else if (reg_addr_i == REG_STATUS) begin
			rdata_nxt[ST_SLEEP_BIT] = sleep_r;
			rdata_nxt[ST_WIPE_BIT]  = wipe_busy_o;
			rdata_nxt[ST_FETCH_BIT] = (st_r != SMAC_IDLE);
		end else if (code_off < 16'(NUM_SLOTS)) begin
			rdata_nxt = {8'h00, code_mem[code_off[4:0]]};
		end else if (scale_off < 16'(NUM_SLOTS)) begin
			rdata_nxt = scaled;
		end else if (float_off < 16'(2 * NUM_SLOTS)) begin
			rdata_nxt = float_off[0] ? float_mem[float_off[5:1]][31:16]
			                         : float_mem[float_off[5:1]][15:0];
		end
	end

	// Registered read data and acknowledge one cycle after each access.
	always_ff @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			reg_rdata_o <= 16'h0;
			reg_ack_o   <= 1'b0;
		end else begin
			reg_ack_o <= query;
			if (reg_rd_i) begin
				reg_rdata_o <= rdata_nxt;
			end
		end
	end

	// Checks on the behaviour above.
	a_sleep_entry: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(!sleep_r && sec_tick && !query && !fetch_req_o && idle_cnt_r == 8'(IDLE_SLEEP_S - 1)) |=> sleep_o)
		else $error("adapter did not sleep after idle period");
	a_refresh_fetch: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(start_refresh && interval_r <= 16'(AUTO_WIPE_S)) |=> (fetch_req_o && st_r == SMAC_FETCH))
		else $error("fetch not issued at interval expiry");
	a_store_value: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		meas_valid_i |=> (float_mem[$past(meas_slot_i)] == $past(meas_float_i)))
		else $error("reading not stored in its slot");
	a_wipe_cmd: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		wipe_cmd |=> (wipe_req_o && wipe_cnt_r == 8'(WIPE_TIME_S)))
		else $error("wipe write did not start a wipe");
	a_auto_wipe: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(start_refresh && interval_r > 16'(AUTO_WIPE_S)) |=> (wipe_req_o && st_r == SMAC_WIPE && !fetch_req_o))
		else $error("long interval did not wipe before reading");
	a_scale_low: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(reg_rd_i && scale_off < 16'(NUM_SLOTS) && scale_rng != 64'h0
		 && $signed(fixed_mem[scale_slot]) <= $signed(scale_rng[63:32]))
		|=> reg_rdata_o == 16'h0000)
		else $error("value below range not clamped to zero");
	a_scale_high: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(reg_rd_i && scale_off < 16'(NUM_SLOTS) && scale_rng != 64'h0
		 && $signed(fixed_mem[scale_slot]) >= $signed(scale_rng[31:0]))
		|=> reg_rdata_o == SCALE_MAX)
		else $error("value above range not clamped to full scale");
	a_float_pair: assert property (@(posedge ref_clk_i) disable iff (reset_i)
		(reg_rd_i && float_off < 16'(2 * NUM_SLOTS) && !float_off[0])
		|=> (reg_ack_o && reg_rdata_o == $past(float_mem[float_off[5:1]][15:0])))
		else $error("low half of value pair misread");
endmodule : smac_top

// ==== rtl/smac_pkg.sv ====
// Shared constants, register map and scaling table for the adapter control block.
package smac_pkg;
	// Clock rate and time units.
	localparam int          CLK_FREQ_HZ    = 200_000_000;
	localparam int          TICKS_PER_SEC  = CLK_FREQ_HZ;
	localparam int          IDLE_SLEEP_S   = 60;
	localparam int          WIPE_TIME_S    = 60;
	localparam int          AUTO_WIPE_S    = 120;
	// Register index map on the holding-register port.
	localparam logic [15:0] REG_INTERVAL   = 16'h0001;
	localparam logic [15:0] REG_WIPE       = 16'h0003;
	localparam logic [15:0] REG_STATUS     = 16'h0004;
	localparam logic [15:0] REG_CODE_BASE  = 16'h0081;
	localparam logic [15:0] REG_SCALE_BASE = 16'h0101;
	localparam logic [15:0] REG_FLOAT_BASE = 16'h0181;
	localparam int          NUM_SLOTS      = 32;
	localparam logic [15:0] INTERVAL_RST   = 16'h0000;
	localparam logic [15:0] SCALE_MAX      = 16'hffff;
	// Status register bit positions.
	localparam int          ST_SLEEP_BIT   = 0;
	localparam int          ST_WIPE_BIT    = 1;
	localparam int          ST_FETCH_BIT   = 2;
	// Refresh sequencer states.
	typedef enum logic [2:0] {
		SMAC_IDLE  = 3'b001,
		SMAC_WIPE  = 3'b010,
		SMAC_FETCH = 3'b100
	} smac_state_e;
	// Scale low and high for a parameter code, in units of 1e-4; both zero means unscaled.
	function automatic logic [63:0] smac_range(input logic [7:0] code);
		logic signed [31:0] lo;
		logic signed [31:0] hi;
		lo = 32'sh0;
		hi = 32'sh0;
		case (code)
			8'd1, 8'd2, 8'd20, 8'd21, 8'd22, 8'd23, 8'd240, 8'd241: begin
				lo = -32'sd500000;
				hi = 32'sd6053500;
			end
			8'd5, 8'd7, 8'd110, 8'd238: begin
				hi = 32'sd655350000;
			end
			8'd10, 8'd12, 8'd28, 8'd95, 8'd212, 8'd229, 8'd230, 8'd239: begin
				hi = 32'sd655350;
			end
			8'd17, 8'd19, 8'd101, 8'd108, 8'd145, 8'd235: begin
				lo = -32'sd16384000;
				hi = 32'sd16383500;
			end
			8'd18: begin
				lo = -32'sd277680;
				hi = 32'sd397670;
			end
			8'd37, 8'd190, 8'd223: begin
				hi = 32'sd65535000;
			end
			8'd191: begin
				hi = 32'sd65535;
			end
			8'd51, 8'd52, 8'd53, 8'd54: begin
				hi = 32'sd0;
			end
			default: begin
				hi = 32'sd6553500;
			end
		endcase
		return {lo, hi};
	endfunction : smac_range
endpackage : smac_pkg

// ==== rtl/smac_scaler.sv ====
// Maps a fixed-point reading onto the 16-bit scaled-integer range of its parameter code.
`timescale 1ns/1ps
module smac_scaler (
	input  wire logic [7:0]  code_i,
	input  wire logic [31:0] value_i,
	output logic      [15:0] scaled_o
);
	import smac_pkg::*;

	logic signed [31:0] lo;
	logic signed [31:0] hi;
	logic signed [63:0] span;
	logic signed [63:0] offs;
	logic        [63:0] quot;
	logic        [63:0] rng;

	// Linear map of low..high onto 0..65535, clamped at both ends; unscaled codes pass through.
	always_comb begin
		rng      = smac_range(code_i);
		lo       = rng[63:32];
		hi       = rng[31:0];
		span     = 64'(hi) - 64'(lo);
		offs     = 64'($signed(value_i)) - 64'(lo);
		quot     = 64'h0;
		scaled_o = value_i[15:0];
		if (span != 64'sh0) begin
			if ($signed(value_i) <= lo) begin
				scaled_o = 16'h0000;
			end else if ($signed(value_i) >= hi) begin
				scaled_o = SCALE_MAX;
			end else begin
				quot     = 64'(offs * 64'sd65535) / 64'(span);
				scaled_o = quot[15:0];
			end
		end
	end
endmodule : smac_scaler

// ==== dv/smac_instr_model.sv ====
// Instrument model: answers each fetch request with two readings and then a done pulse.
`timescale 1ns/1ps
module smac_instr_model (
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic        req_i,
	input  wire logic        slow_i,
	input  wire logic [31:0] flt_i,
	input  wire logic [31:0] fix_i,
	output logic             done_o,
	output logic             vld_o,
	output logic      [4:0]  slot_o,
	output logic      [31:0] flt_o,
	output logic      [31:0] fix_o
);
	int n = 0;
	// Outputs move on falling edges; idle data lines toggle so a stale value is never trusted.
	always @(negedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			n <= 0;
			{done_o, vld_o, slot_o, flt_o, fix_o} <= '0;
		end else begin
			done_o <= 1'b0;
			vld_o <= 1'b0;
			flt_o <= ~flt_o;
			fix_o <= ~fix_o;
			n <= req_i ? 1 : (n == 0 ? 0 : n + 1);
			if (n == (slow_i ? 40 : 2)) begin
				vld_o <= 1'b1;
				slot_o <= 5'h00;
				flt_o <= flt_i;
				fix_o <= fix_i;
			end
			if (n == (slow_i ? 41 : 3)) begin
				vld_o <= 1'b1;
				slot_o <= 5'h01;
				flt_o <= 32'h42480000;
				fix_o <= 32'd500000;
			end
			if (n == (slow_i ? 42 : 4)) begin
				done_o <= 1'b1;
				n <= 0;
			end
		end
	end
endmodule : smac_instr_model

// ==== dv/sonde_modbus_adapter_control_tb.sv ====
// Bench for the adapter control block: registers, sleep, wipe, refresh pacing and scaling.
`timescale 1ns/1ps
module sonde_modbus_adapter_control_tb;
	import smac_pkg::*;
	localparam int     TPS  = 10;
	localparam longint SC_A = 64'd751100 * 65535 / 6553500;
	localparam longint SC_B = 64'd572300 * 65535 / 6553500;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [15:0] wdat = 16'h0000;
	logic [15:0] rdat;
	logic        ack;
	logic        freq;
	logic        fdone;
	logic        wreq;
	logic        mvld;
	logic [4:0]  mslot;
	logic [31:0] mflt;
	logic [31:0] mfix;
	logic        slp;
	logic        wbusy;
	logic        slow = 1'b0;
	logic [31:0] flt0 = 32'h41c8e147;
	logic [31:0] fix0 = 32'd251100;
	logic [15:0] rv;
	int          miscompares = 0;
	int          num_checks = 0;
	int          cyc = 0;
	int          fcnt = 0;
	int          wcnt = 0;
	int          wat = 0;
	int          fat = 0;
	int          n0;
	int          t1;
	logic [47:0] rows [5] = '{{REG_INTERVAL, 16'h0005, 16'h0005}, {16'h0002, 16'habcd, 16'h0000},
		{REG_CODE_BASE, 16'h12f0, 16'h00f0}, {16'h00a0, 16'h0017, 16'h0017}, {REG_INTERVAL, 16'h0000, 16'h0000}};

	smac_top #(.TICKS_PER_SEC(TPS)) i_dut (.ref_clk_i(clk), .reset_i(rst), .reg_wr_i(wr), .reg_rd_i(rd),
		.reg_addr_i(addr), .reg_wdata_i(wdat), .reg_rdata_o(rdat), .reg_ack_o(ack), .fetch_req_o(freq),
		.fetch_done_i(fdone), .wipe_req_o(wreq), .meas_valid_i(mvld), .meas_slot_i(mslot),
		.meas_float_i(mflt), .meas_fixed_i(mfix), .sleep_o(slp), .wipe_busy_o(wbusy));

	smac_instr_model i_instr (.clk_i(clk), .reset_i(rst), .req_i(freq), .slow_i(slow), .flt_i(flt0),
		.fix_i(fix0), .done_o(fdone), .vld_o(mvld), .slot_o(mslot), .flt_o(mflt), .fix_o(mfix));

	// Clock at 200 MHz.
	always #2.5 clk = ~clk;

	// Counts request pulses and cuts a hung run short.
	always @(posedge clk) begin
		cyc++;
		if (freq === 1'b1) begin
			fcnt++;
			fat = cyc;
		end
		if (wreq === 1'b1) begin
			wcnt++;
			wat = cyc;
		end
		if (cyc == 15000) begin
			miscompares++;
			complete_run();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// One register access: a single-cycle strobe, then the acknowledge is awaited.
	task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
		@(negedge clk);
		wr = w;
		rd = !w;
		addr = a;
		wdat = d;
		@(negedge clk);
		wr = 1'b0;
		rd = 1'b0;
		for (int i = 0; i < 4 && ack !== 1'b1; i++) @(negedge clk);
		check({15'h0, ack}, 16'h0001);
		rv = rdat;
	endtask : acc

	task automatic wait_cnt(ref int c, input int n, input int lim);
		for (int i = 0; i < lim && c < n; i++) @(negedge clk);
		check({15'h0, c >= n}, 16'h0001);
	endtask : wait_cnt

	task automatic read_vals(input logic [15:0] sc);
		acc(1'b0, REG_FLOAT_BASE, 16'h0000);
		check(rv, flt0[15:0]);
		acc(1'b0, REG_FLOAT_BASE + 16'h0001, 16'h0000);
		check(rv, flt0[31:16]);
		acc(1'b0, REG_SCALE_BASE, 16'h0000);
		check(rv, sc);
	endtask : read_vals

	task automatic complete_run;
		$display("checks=%0d mismatches=%0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : complete_run

	initial begin
		repeat (20) @(negedge clk);
		rst = 1'b0;
		check({15'h0, slp}, 16'h0000);
		acc(1'b0, REG_INTERVAL, 16'h0000);
		check(rv, INTERVAL_RST);
		// Each row is written and read back.
		foreach (rows[i]) begin
			acc(1'b1, rows[i][47:32], rows[i][31:16]);
			acc(1'b0, rows[i][47:32], 16'h0000);
			check(rv, rows[i][15:0]);
		end
		// The host stays quiet past the idle limit, then queries again.
		repeat (TPS * 58) @(negedge clk);
		check({15'h0, slp}, 16'h0000);
		repeat (TPS * 4) @(negedge clk);
		check({15'h0, slp}, 16'h0001);
		acc(1'b0, REG_STATUS, 16'h0000);
		check(rv, 16'h0001);
		repeat (2) @(negedge clk);
		check({15'h0, slp}, 16'h0000);
		// Manual wipe; values are not read while it runs.
		acc(1'b1, REG_WIPE, 16'h5a5a);
		repeat (2) @(negedge clk);
		check(wcnt[15:0], 16'h0001);
		check({15'h0, wbusy}, 16'h0001);
		acc(1'b0, REG_WIPE, 16'h0000);
		check(rv, 16'h0000);
		acc(1'b0, REG_STATUS, 16'h0000);
		check(rv, 16'h0002);
		repeat (TPS * 57) @(negedge clk);
		check({15'h0, wbusy}, 16'h0001);
		repeat (TPS * 4) @(negedge clk);
		check({15'h0, wbusy}, 16'h0000);
		// Paced refresh with slot codes for temperature and pH.
		acc(1'b1, REG_CODE_BASE, 16'h0001);
		acc(1'b1, REG_CODE_BASE + 16'h0001, 16'h0012);
		acc(1'b1, REG_INTERVAL, 16'h0002);
		n0 = fcnt;
		wait_cnt(fcnt, n0 + 1, TPS * 4);
		t1 = fat;
		wait_cnt(fcnt, n0 + 2, TPS * 4);
		check({15'h0, fat - t1 >= 2 * TPS - 2 && fat - t1 <= 3 * TPS + 6}, 16'h0001);
		read_vals(SC_A[15:0]);
		acc(1'b0, REG_FLOAT_BASE + 16'h0003, 16'h0000);
		check(rv, 16'h4248);
		acc(1'b0, REG_SCALE_BASE + 16'h0001, 16'h0000);
		check(rv, SCALE_MAX);
		// New readings with a slow instrument must overwrite the old ones.
		flt0 = 32'h40e75c29;
		fix0 = 32'd72300;
		slow = 1'b1;
		n0 = fcnt;
		wait_cnt(fcnt, n0 + 2, TPS * 20);
		acc(1'b0, REG_STATUS, 16'h0000);
		check(rv, 16'h0004);
		repeat (48) @(negedge clk);
		read_vals(SC_B[15:0]);
		// Above two minutes a wipe precedes each fetch by one wipe window.
		slow = 1'b0;
		acc(1'b1, REG_INTERVAL, 16'h0079);
		n0 = wcnt;
		wait_cnt(wcnt, n0 + 1, TPS * 125);
		n0 = fcnt;
		wait_cnt(fcnt, n0 + 1, TPS * 62);
		check({15'h0, fat - wat >= TPS * 59 && fat - wat <= TPS * 61 + 2}, 16'h0001);
		// Exactly two minutes fetches without a wipe.
		acc(1'b1, REG_INTERVAL, 16'h0078);
		n0 = fcnt;
		wait_cnt(fcnt, n0 + 1, TPS * 125);
		t1 = wcnt;
		wait_cnt(fcnt, n0 + 2, TPS * 125);
		check(wcnt[15:0] - t1[15:0], 16'h0000);
		// A reading below its range clamps to zero and a date code passes through unscaled.
		fix0 = 32'hfffe7960;
		acc(1'b1, REG_CODE_BASE, 16'h0003);
		acc(1'b1, REG_CODE_BASE + 16'h0001, 16'h0033);
		acc(1'b1, REG_INTERVAL, 16'h0001);
		n0 = fcnt;
		wait_cnt(fcnt, n0 + 1, TPS * 4);
		t1 = fat;
		wait_cnt(fcnt, n0 + 2, TPS * 4);
		check(fat[15:0] - t1[15:0], 16'(TPS));
		repeat (10) @(negedge clk);
		acc(1'b0, REG_SCALE_BASE, 16'h0000);
		check(rv, 16'h0000);
		acc(1'b0, REG_SCALE_BASE + 16'h0001, 16'h0000);
		check(rv, 16'ha120);
		// A reset in mid-run returns outputs and registers to their idle values.
		@(negedge clk);
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		check({14'h0, freq, wreq}, 16'h0000);
		check({14'h0, wbusy, slp}, 16'h0000);
		check({15'h0, ack}, 16'h0000);
		check(rdat, 16'h0000);
		acc(1'b0, REG_INTERVAL, 16'h0000);
		check(rv, INTERVAL_RST);
		acc(1'b0, REG_CODE_BASE, 16'h0000);
		check(rv, 16'h0000);
		complete_run();
	end
endmodule : sonde_modbus_adapter_control_tb
